// file: core/ccpd_clock_ctrl.sv
/*
  Clock controller: system and tick clock selection, crystal stop
  supervision with fast-crystal fallback, power-down entry and wake-up, and the
  power-of-two clock output divider.
  Assumes oscillator waveforms and stable flags arrive asynchronously, and
  that the core's wait-for-interrupt and wake inputs share this clock.
*/
`timescale 1ns/100ps
`default_nettype none

module ccpd_clock_ctrl
  import ccpd_pkg::*;
#(
  parameter int PERIPH_COUNT = 8,
  parameter int SLOW_TIMEOUT = ccpd_pkg::SLOW_FAIL_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Software control registers
  input wire logic [7:0] power_control_reg,
  input wire logic [7:0] clock_select_reg,
  input wire logic [15:0] detector_control_reg,
  input wire logic [7:0] clock_output_control_reg,
  input wire logic [7:0] tick_timer_control_reg,
  input wire logic [1:0] fail_flag_clear,
  // Core handshake
  input wire logic wait_for_interrupt_instruction,
  input wire logic wake_interrupt,
  // Oscillators (asynchronous)
  input wire logic [1:0] crystal_wave,
  input wire logic [3:0] osc_stable,
  // Peripheral gate requests
  input wire logic [PERIPH_COUNT-1:0] periph_clock_enable,
  input wire logic [PERIPH_COUNT-1:0] periph_on_slow,
  // Oscillator enables
  output logic external_fast_crystal_enable,
  output logic external_slow_crystal_enable,
  output logic internal_fast_oscillator_enable,
  output logic internal_slow_oscillator_enable,
  // Clock routing and gates
  output logic [2:0] system_clock_source,
  output logic system_clock_on,
  output logic tick_use_external,
  output logic [2:0] tick_clock_source,
  output logic tick_clock_valid,
  output logic [PERIPH_COUNT-1:0] periph_clock_on,
  output logic clock_output_pin,
  // Status
  output logic [1:0] detector_status_reg,
  output logic clock_fail_irq,
  output logic powered_down
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [2:0] SW_LAST = 3'(SWITCH_CYCLES - 1);

  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [1:0] wave_s;
  logic [3:0] stable_s;
  ccpd_pm_t pm_state;
  ccpd_pm_t next_pm_state;
  ccpd_sw_t sw_state;
  logic [2:0] sw_count;
  logic [2:0] sys_request;
  logic [2:0] sys_field;
  logic force_internal_fast_oscillator;
  logic fast_stop;
  logic slow_stop;
  logic fast_det_en;
  logic slow_det_en;
  logic entry_ok;
  logic next_down;
  logic [15:0] div_count;
  logic [15:0] next_div_count;
  logic div_run;
  logic div_bit;
  logic out_en;

  // Source code to synchronised stable flag
  function automatic logic source_ready(input logic [2:0] code, input logic [3:0] st);
    case (code)
      SRC_HXT: source_ready = st[OSC_HXT];
      SRC_LXT: source_ready = st[OSC_LXT];
      SRC_INTERNAL_SLOW_OSCILLATOR: source_ready = st[OSC_INTERNAL_SLOW_OSCILLATOR];
      default: source_ready = st[OSC_INTERNAL_FAST_OSCILLATOR];
    endcase
  endfunction : source_ready

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Two stages for every oscillator-side input; stage one feeds only stage two
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {osc_stable, crystal_wave};
      sync_b <= sync_a;
    end
  end

  assign wave_s = sync_b[1:0];
  assign stable_s = sync_b[5:2];
  assign fast_det_en = detector_control_reg[DET_FAST_EN_BIT];
  assign slow_det_en = detector_control_reg[DET_SLOW_EN_BIT];

  // ----------------------------------------------------------------------
  // Crystal stop detectors
  // ----------------------------------------------------------------------
  ccpd_fail_detect #(
    .TIMEOUT(FAST_FAIL_CYCLES)
  ) u_fast_detect (
    .clock(clock),
    .reset(reset),
    .enable(fast_det_en & external_fast_crystal_enable),
    .osc_level(wave_s[OSC_HXT]),
    .stop_pulse(fast_stop)
  );

  ccpd_fail_detect #(
    .TIMEOUT(SLOW_TIMEOUT)
  ) u_slow_detect (
    .clock(clock),
    .reset(reset),
    .enable(slow_det_en & external_slow_crystal_enable),
    .osc_level(wave_s[OSC_LXT]),
    .stop_pulse(slow_stop)
  );

  // Sticky fail flags; a stop in the clear cycle wins over the clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      detector_status_reg <= 2'b00;
    end else begin
      detector_status_reg[STS_FAST_FAIL_BIT] <= fast_stop |
        (detector_status_reg[STS_FAST_FAIL_BIT] & ~fail_flag_clear[STS_FAST_FAIL_BIT]);
      detector_status_reg[STS_SLOW_FAIL_BIT] <= slow_stop |
        (detector_status_reg[STS_SLOW_FAIL_BIT] & ~fail_flag_clear[STS_SLOW_FAIL_BIT]);
    end
  end

  // Interrupt only through each detector's own enable
  assign clock_fail_irq = (detector_status_reg[STS_FAST_FAIL_BIT] & detector_control_reg[DET_FAST_IRQ_BIT]) |
    (detector_status_reg[STS_SLOW_FAIL_BIT] & detector_control_reg[DET_SLOW_IRQ_BIT]);

  // Fallback latch: held until software clears the fast flag, so a dead
  // crystal is never reselected behind software's back
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      force_internal_fast_oscillator <= 1'b0;
    end else if (fast_stop && fast_det_en && system_clock_source == SRC_HXT) begin
      force_internal_fast_oscillator <= 1'b1;
    end else if (fail_flag_clear[STS_FAST_FAIL_BIT]) begin
      force_internal_fast_oscillator <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Power-down sequencing
  // ----------------------------------------------------------------------
  assign entry_ok = wait_for_interrupt_instruction & power_control_reg[PWR_PD_BIT];

  // Next power state
  always_comb begin
    next_pm_state = pm_state;
    case (pm_state)
      CCPD_RUN: begin
        if (entry_ok && sw_state == CCPD_SW_IDLE) begin
          next_pm_state = CCPD_DOWN;
        end
      end
      CCPD_DOWN: begin
        if (wake_interrupt) begin
          next_pm_state = CCPD_WAKE;
        end
      end
      CCPD_WAKE: begin
        if (source_ready(system_clock_source, stable_s)) begin
          next_pm_state = CCPD_RUN;
        end
      end
      default: next_pm_state = CCPD_RUN;
    endcase
  end

  // Power state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pm_state <= CCPD_RUN;
    end else begin
      pm_state <= next_pm_state;
    end
  end

  assign powered_down = (pm_state == CCPD_DOWN);
  assign next_down = (next_pm_state == CCPD_DOWN);

  // Fast oscillator enables follow the next state so they drop with entry
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      external_fast_crystal_enable <= 1'b0;
      external_slow_crystal_enable <= 1'b0;
      internal_fast_oscillator_enable <= 1'b1;
      internal_slow_oscillator_enable <= 1'b0;
    end else begin
      external_fast_crystal_enable <= power_control_reg[PWR_HXT_EN_BIT] & ~next_down;
      internal_fast_oscillator_enable <= (power_control_reg[PWR_INTERNAL_FAST_OSCILLATOR_EN_BIT] | fast_det_en |
        (system_clock_source == SRC_INTERNAL_FAST_OSCILLATOR)) & ~next_down;
      external_slow_crystal_enable <= power_control_reg[PWR_LXT_EN_BIT];
      internal_slow_oscillator_enable <= power_control_reg[PWR_INTERNAL_SLOW_OSCILLATOR_EN_BIT] | slow_det_en;
    end
  end

  // ----------------------------------------------------------------------
  // System clock selection
  // ----------------------------------------------------------------------
  assign sys_field = clock_select_reg[SEL_SYS_LSB +: 3];

  // Unmapped codes fall back to the internal fast oscillator
  always_comb begin
    case (sys_field)
      SRC_HXT, SRC_LXT, SRC_INTERNAL_SLOW_OSCILLATOR: sys_request = force_internal_fast_oscillator ? SRC_INTERNAL_FAST_OSCILLATOR : sys_field;
      default: sys_request = SRC_INTERNAL_FAST_OSCILLATOR;
    endcase
  end

  // Switch waits for the new source to be stable for the settle time;
  // the system gate is off meanwhile so no pulse is ever cut short
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sw_state <= CCPD_SW_IDLE;
      sw_count <= 3'h0;
      system_clock_source <= SYS_SRC_RESET;
    end else begin
      case (sw_state)
        CCPD_SW_IDLE: begin
          sw_count <= 3'h0;
          if (pm_state == CCPD_RUN && sys_request != system_clock_source) begin
            sw_state <= CCPD_SW_WAIT;
          end
        end
        CCPD_SW_WAIT: begin
          if (sys_request == system_clock_source) begin
            sw_state <= CCPD_SW_IDLE;
          end else if (!source_ready(sys_request, stable_s)) begin
            sw_count <= 3'h0;
          end else if (sw_count == SW_LAST) begin
            system_clock_source <= sys_request;
            sw_state <= CCPD_SW_IDLE;
          end else begin
            sw_count <= sw_count + 3'h1;
          end
        end
        default: sw_state <= CCPD_SW_IDLE;
      endcase
    end
  end

  // Clock gates: system off in power-down, wake and switching; peripherals
  // on slow sources survive power-down
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      system_clock_on <= 1'b0;
      periph_clock_on <= '0;
    end else begin
      system_clock_on <= (next_pm_state == CCPD_RUN) && sw_state == CCPD_SW_IDLE &&
        !(pm_state == CCPD_RUN && sys_request != system_clock_source);
      periph_clock_on <= periph_clock_enable & (periph_on_slow | {PERIPH_COUNT{~next_down}});
    end
  end

  // ----------------------------------------------------------------------
  // Tick timer clock
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_use_external <= 1'b0;
      tick_clock_source <= TICK_SRC_RESET;
      tick_clock_valid <= 1'b1;
    end else begin
      tick_use_external <= tick_timer_control_reg[TICK_EXT_BIT];
      tick_clock_source <= clock_select_reg[SEL_TICK_LSB +: 3];
      tick_clock_valid <= clock_select_reg[SEL_TICK_LSB +: 3] < TICK_SRC_COUNT;
    end
  end

  // ----------------------------------------------------------------------
  // Clock output divider
  // ----------------------------------------------------------------------
  assign out_en = clock_output_control_reg[OUT_EN_BIT];
  // Counter bit k toggles every 2^k input cycles, i.e. one stage per bit
  assign next_div_count = (div_run && (out_en || clock_output_pin) && system_clock_on) ?
    div_count + 16'h0001 : div_count;
  assign div_bit = next_div_count[clock_output_control_reg[OUT_DIV_LSB +: 4]];

  // Divider runs while enabled, and after disable only until it reads low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      div_count <= DIV_COUNT_RESET;
      div_run <= 1'b0;
      clock_output_pin <= 1'b0;
    end else begin
      div_count <= next_div_count;
      div_run <= out_en | (div_run & clock_output_pin);
      clock_output_pin <= (out_en | (div_run & clock_output_pin)) & div_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_entry;
    pm_state == CCPD_RUN && entry_ok && sw_state == CCPD_SW_IDLE;
  endsequence

  sequence s_asleep;
    powered_down && !wake_interrupt;
  endsequence

  a_pd_entry_cause: assert property ($rose(powered_down) |-> $past(entry_ok))
    else $error("power-down entered without enable and wait-for-interrupt");
  a_pd_entry_taken: assert property (s_entry |=> powered_down)
    else $error("qualified power-down request not taken");
  a_pd_fast_off: assert property (powered_down |-> !external_fast_crystal_enable && !internal_fast_oscillator_enable)
    else $error("fast oscillators running in power-down");
  a_pd_wake_hold: assert property (s_asleep |=> powered_down)
    else $error("left power-down without wake-up");
  a_pd_wake_leave: assert property (powered_down && wake_interrupt |=> !powered_down ##1 !powered_down)
    else $error("wake-up did not end power-down");
  a_fast_fallback: assert property (fast_stop && fast_det_en && system_clock_source == SRC_HXT
    |=> force_internal_fast_oscillator && sys_request == SRC_INTERNAL_FAST_OSCILLATOR)
    else $error("fast crystal stop did not force fallback");
  a_irq_masked: assert property (!detector_control_reg[DET_FAST_IRQ_BIT] && !detector_control_reg[DET_SLOW_IRQ_BIT]
    |-> !clock_fail_irq)
    else $error("fail interrupt raised while disabled");
  a_slow_kept: assert property (powered_down && power_control_reg[PWR_INTERNAL_SLOW_OSCILLATOR_EN_BIT]
    && $past(power_control_reg[PWR_INTERNAL_SLOW_OSCILLATOR_EN_BIT]) |-> internal_slow_oscillator_enable)
    else $error("slow oscillator stopped in power-down");
  a_clock_output_pin_low_idle: assert property (!out_en && !div_run |=> !clock_output_pin)
    else $error("clock output not held low after disable");
  a_switch_gated: assert property ($changed(system_clock_source) |-> !system_clock_on)
    else $error("system clock gate open during source change");
  a_wake_release: assert property ($past(pm_state) == CCPD_WAKE && pm_state == CCPD_RUN
    |-> $past(source_ready(system_clock_source, stable_s)))
    else $error("clock released before source stable");

endmodule : ccpd_clock_ctrl

`default_nettype wire

// file: core/ccpd_pkg.sv
/*
  Constants shared by the clock controller: field positions, source codes,
  reset values, timing figures and state encodings.
  Assumes a single 250 MHz controller clock.
*/
package ccpd_pkg;

  // ----------------------------------------------------------------------
  // Controller clock
  // ----------------------------------------------------------------------
  localparam int CLOCK_PERIOD_PS = 4000;

  // ----------------------------------------------------------------------
  // Timing (least times, rounded up to whole cycles)
  // ----------------------------------------------------------------------
  localparam int FAST_FAIL_NS = 1000;
  localparam int FAST_FAIL_CYCLES = (FAST_FAIL_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int SLOW_FAIL_NS = 100000;
  localparam int SLOW_FAIL_CYCLES = (SLOW_FAIL_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int SWITCH_SETTLE_NS = 32;
  localparam int SWITCH_CYCLES = (SWITCH_SETTLE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PWR_HXT_EN_BIT = 0;
  localparam int PWR_LXT_EN_BIT = 1;
  localparam int PWR_INTERNAL_FAST_OSCILLATOR_EN_BIT = 2;
  localparam int PWR_INTERNAL_SLOW_OSCILLATOR_EN_BIT = 3;
  localparam int PWR_PD_BIT = 7;
  localparam int SEL_SYS_LSB = 0;
  localparam int SEL_TICK_LSB = 3;
  localparam int DET_FAST_EN_BIT = 4;
  localparam int DET_FAST_IRQ_BIT = 5;
  localparam int DET_SLOW_EN_BIT = 12;
  localparam int DET_SLOW_IRQ_BIT = 13;
  localparam int STS_FAST_FAIL_BIT = 0;
  localparam int STS_SLOW_FAIL_BIT = 1;
  localparam int TICK_EXT_BIT = 2;
  localparam int OUT_DIV_LSB = 0;
  localparam int OUT_EN_BIT = 4;

  // Oscillator index in the stable / waveform input vectors
  localparam int OSC_HXT = 0;
  localparam int OSC_LXT = 1;
  localparam int OSC_INTERNAL_FAST_OSCILLATOR = 2;
  localparam int OSC_INTERNAL_SLOW_OSCILLATOR = 3;

  // ----------------------------------------------------------------------
  // Source codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_HXT = 3'h0;
  localparam logic [2:0] SRC_LXT = 3'h1;
  localparam logic [2:0] SRC_INTERNAL_SLOW_OSCILLATOR = 3'h3;
  localparam logic [2:0] SRC_INTERNAL_FAST_OSCILLATOR = 3'h7;
  localparam logic [2:0] SYS_SRC_RESET = 3'h7;
  localparam logic [2:0] TICK_SRC_COUNT = 3'h5;
  localparam logic [2:0] TICK_SRC_RESET = 3'h0;
  localparam logic [15:0] DIV_COUNT_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCPD_RUN = 2'b00,
    CCPD_DOWN = 2'b01,
    CCPD_WAKE = 2'b10
  } ccpd_pm_t;

  typedef enum logic [0:0] {
    CCPD_SW_IDLE = 1'b0,
    CCPD_SW_WAIT = 1'b1
  } ccpd_sw_t;

endpackage : ccpd_pkg

// file: core/ccpd_fail_detect.sv
/*
  Crystal stop detector: watches a synchronised oscillator waveform and
  pulses once when no edge has been seen for TIMEOUT cycles.
  Assumes osc_level has already passed a two-stage synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none

module ccpd_fail_detect #(
  parameter int TIMEOUT = 250
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control and observed waveform
  input wire logic enable,
  input wire logic osc_level,
  // Event
  output logic stop_pulse
);

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT - 1);

  logic prev_level;
  logic [CW-1:0] quiet_count;
  logic stopped;
  logic edge_seen;

  assign edge_seen = osc_level ^ prev_level;

  // Edge history
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= osc_level;
    end
  end

  // Quiet-time counter; rearmed by any edge or while disabled
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      quiet_count <= '0;
      stopped <= 1'b0;
      stop_pulse <= 1'b0;
    end else if (!enable || edge_seen) begin
      quiet_count <= '0;
      stopped <= 1'b0;
      stop_pulse <= 1'b0;
    end else if (quiet_count == LIMIT && !stopped) begin
      stopped <= 1'b1; // One report per stop, not one per cycle
      stop_pulse <= 1'b1;
    end else begin
      quiet_count <= (quiet_count == LIMIT) ? quiet_count : quiet_count + 1'b1;
      stop_pulse <= 1'b0;
    end
  end

  a_stop_needs_quiet: assert property (@(posedge clock) disable iff (reset)
    $rose(stop_pulse) |-> $past(enable) && !$past(edge_seen) && $past(quiet_count) == LIMIT)
    else $error("stop reported without a full quiet interval");

endmodule : ccpd_fail_detect

`default_nettype wire

// file: test/ccpd_osc_model.sv
/*
  Oscillator model: two crystal waveforms and four stable flags that follow
  the controller's oscillator enables.
  Assumes the enables come from the controller and the stop requests from the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module ccpd_osc_model #(
  parameter int SETTLE = 12
) (
  // Clock
  input wire logic clock,
  // Enables and injected faults
  input wire logic [3:0] osc_enable,
  input wire logic [1:0] stop_request,
  // Oscillator outputs
  output logic [1:0] crystal_wave,
  output logic [3:0] osc_stable
);
  int count [4];

  // Free-running crystals on their own time base; a stopped one rests low
  initial crystal_wave = 2'b00;
  always #7.3 crystal_wave[0] = osc_enable[0] && !stop_request[0] && !crystal_wave[0];
  always #51.1 crystal_wave[1] = osc_enable[1] && !stop_request[1] && !crystal_wave[1];

  // Stable only after a settle time; a disabled oscillator drops it at once
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      count[i] <= osc_enable[i] ? (count[i] < SETTLE ? count[i] + 1 : count[i]) : 0;
      osc_stable[i] <= osc_enable[i] && count[i] >= SETTLE;
    end
  end
endmodule : ccpd_osc_model

`default_nettype wire

// file: test/ccpd_clock_ctrl_tb.sv
/*
  Self-checking bench for the clock controller with an oscillator model.
  Assumes the package, the design files and ccpd_osc_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module ccpd_clock_ctrl_tb;
  import ccpd_pkg::*;
  logic clock = 0, reset = 1, wait_for_interrupt_instruction = 0, wake_interrupt = 0;
  logic [7:0] power_control_reg = 8'h0C, clock_select_reg = 8'h07, clock_output_control_reg = 8'h00;
  logic [7:0] tick_timer_control_reg = 8'h00, periph_clock_enable = 8'h00, periph_on_slow = 8'h00;
  logic [15:0] detector_control_reg = 16'h0000;
  logic [1:0] fail_flag_clear = 2'h0, stop_request = 2'h0, crystal_wave, detector_status_reg;
  logic [3:0] osc_stable;
  logic [7:0] periph_clock_on;
  logic [2:0] system_clock_source, tick_clock_source;
  logic external_fast_crystal_enable, external_slow_crystal_enable, internal_fast_oscillator_enable;
  logic internal_slow_oscillator_enable, system_clock_on, tick_use_external, tick_clock_valid;
  logic clock_output_pin, clock_fail_irq, powered_down;
  int fails = 0, n_compared = 0, seed = 3655, i, j, k, n;

  ccpd_clock_ctrl #(.PERIPH_COUNT(8), .SLOW_TIMEOUT(40)) uut (.clock, .reset, .power_control_reg,
    .clock_select_reg, .detector_control_reg, .clock_output_control_reg, .tick_timer_control_reg,
    .fail_flag_clear, .wait_for_interrupt_instruction, .wake_interrupt, .crystal_wave, .osc_stable,
    .periph_clock_enable, .periph_on_slow, .external_fast_crystal_enable, .external_slow_crystal_enable,
    .internal_fast_oscillator_enable, .internal_slow_oscillator_enable, .system_clock_source,
    .system_clock_on, .tick_use_external, .tick_clock_source, .tick_clock_valid, .periph_clock_on,
    .clock_output_pin, .detector_status_reg, .clock_fail_irq, .powered_down);

  ccpd_osc_model osc (.clock, .stop_request, .crystal_wave, .osc_stable,
    .osc_enable({internal_slow_oscillator_enable, internal_fast_oscillator_enable,
      external_slow_crystal_enable, external_fast_crystal_enable}));

  // 250 MHz controller clock
  always #2 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // A wait that used up its bound ends the run
  task automatic bound(input int got, input int lim);
    if (got >= lim) begin
      fails++;
      tally_and_finish();
    end
  endtask : bound

  // Single-cycle core request, then settle to the next falling edge
  task automatic pulse_wfi();
    @(posedge clock) wait_for_interrupt_instruction <= 1;
    @(posedge clock) wait_for_interrupt_instruction <= 0;
    @(negedge clock);
  endtask : pulse_wfi

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    reset <= 0;
    @(negedge clock);
    check(system_clock_source, SYS_SRC_RESET);
    // Divider: measure both phases, then stop in mid-high phase
    for (k = 0; k < 4; k++) begin
      n = (k < 3) ? k : 3 + ($random(seed) & 3);
      @(posedge clock) clock_output_control_reg <= 8'h10 | n[7:0];
      for (i = 0; i < 300 && clock_output_pin !== 1; i++) @(negedge clock);
      bound(i, 300);
      // First high phase may be cut short by a count left from the last run
      for (i = 0; i < 300 && clock_output_pin === 1; i++) @(negedge clock);
      for (i = 0; i < 300 && clock_output_pin !== 1; i++) @(negedge clock);
      for (i = 0; i < 300 && clock_output_pin === 1; i++) @(negedge clock);
      for (j = 0; j < 300 && clock_output_pin === 0; j++) @(negedge clock);
      check(i + j, 2 ** (n + 1));
      @(posedge clock) clock_output_control_reg <= n[7:0];
      @(negedge clock);
      for (i = 1; i < 300 && clock_output_pin === 1; i++) @(negedge clock);
      check(i, 2 ** n);
      j = 0;
      repeat (300) begin
        @(negedge clock);
        if (clock_output_pin !== 0) j++;
      end
      check(j, 0);
    end
    // Tick clock: every source code with a random external-select bit
    for (k = 0; k < 8; k++) begin
      n = $random(seed);
      @(posedge clock) clock_select_reg <= {2'b00, k[2:0], 3'h7};
      tick_timer_control_reg <= n[7:0];
      repeat (2) @(negedge clock);
      check({tick_use_external, tick_clock_source, tick_clock_valid}, {n[2], k[2:0], k < 5});
    end
    // Move to the fast crystal under supervision, then stop it
    @(posedge clock) power_control_reg <= 8'h09;
    clock_select_reg <= {2'b00, 3'h0, SRC_HXT};
    detector_control_reg <= 16'h0030;
    for (i = 0; i < 200 && system_clock_source !== SRC_HXT; i++) @(negedge clock);
    bound(i, 200);
    check(internal_fast_oscillator_enable, 1);
    @(posedge clock) periph_clock_enable <= 8'($random(seed));
    periph_on_slow <= 8'($random(seed));
    stop_request <= 2'b01;
    for (i = 0; i < 600 && detector_status_reg[0] !== 1; i++) @(negedge clock);
    bound(i, 600);
    check(clock_fail_irq, 1);
    for (i = 0; i < 200 && system_clock_source !== SRC_INTERNAL_FAST_OSCILLATOR; i++) @(negedge clock);
    bound(i, 200);
    @(posedge clock) detector_control_reg <= 16'h0010;
    @(negedge clock);
    check({clock_fail_irq, detector_status_reg[0]}, 2'b01);
    // Recovery: park on the internal oscillator, cycle the crystal, await stable
    @(posedge clock) stop_request <= 2'b00;
    fail_flag_clear <= 2'b01;
    power_control_reg <= 8'h08;
    clock_select_reg <= 8'h07;
    @(posedge clock) fail_flag_clear <= 2'b00;
    power_control_reg <= 8'h09;
    for (i = 0; i < 20 && osc_stable[0] !== 0; i++) @(negedge clock);
    bound(i, 20);
    for (i = 0; i < 200 && osc_stable[0] !== 1; i++) @(negedge clock);
    bound(i, 200);
    @(posedge clock) clock_select_reg <= 8'h00;
    for (i = 0; i < 200 && system_clock_source !== SRC_HXT; i++) @(negedge clock);
    bound(i, 200);
    check({periph_clock_on, detector_status_reg}, {periph_clock_enable, 2'b00});
    // Slow detector: forces the slow oscillator on, flags a slow stop
    @(posedge clock) power_control_reg <= 8'h03;
    detector_control_reg <= 16'h3000;
    repeat (40) @(negedge clock);
    check(internal_slow_oscillator_enable, 1);
    stop_request <= 2'b10;
    for (i = 0; i < 800 && detector_status_reg[1] !== 1; i++) @(negedge clock);
    bound(i, 800);
    check(clock_fail_irq, 1);
    @(posedge clock) stop_request <= 2'b00;
    fail_flag_clear <= 2'b10;
    @(posedge clock) fail_flag_clear <= 2'b00;
    repeat (60) @(negedge clock);
    // Power-down needs both the enable bit and the core request
    pulse_wfi();
    check(powered_down, 0);
    @(posedge clock) power_control_reg <= 8'h8B;
    repeat (4) @(negedge clock);
    check(powered_down, 0);
    pulse_wfi();
    check({powered_down, external_fast_crystal_enable, internal_fast_oscillator_enable}, 3'b100);
    check({external_slow_crystal_enable, periph_clock_on}, {1'b1, periph_clock_enable & periph_on_slow});
    repeat (6) @(negedge clock);
    check(powered_down, 1);
    @(posedge clock) wake_interrupt <= 1;
    power_control_reg <= 8'h03;
    @(posedge clock) wake_interrupt <= 0;
    @(negedge clock);
    check(powered_down, 0);
    for (i = 0; i < 200 && system_clock_on !== 1; i++) @(negedge clock);
    bound(i, 200);
    check({external_fast_crystal_enable, system_clock_source}, {1'b1, SRC_HXT});
    tally_and_finish();
  end
endmodule : ccpd_clock_ctrl_tb

`default_nettype wire
